// File: rtl/gpc_handler.sv
// Global parameter command handler: frame receive, set/get/store/restore.
// Assumes rx bytes arrive one per strobe and the nonvolatile store answers with nv_done.
`timescale 1ns/1ns
module gpc_handler #(
    parameter int NUM_PARAMS = 256,
    parameter logic [7:0] MY_ADDRESS = 8'h01
) (
    input wire logic clock,              // 50 MHz system clock
    input wire logic reset_n,            // Asynchronous reset, active low
    input wire logic rx_valid,           // Frame byte strobe
    input wire logic [7:0] rx_byte,      // Frame byte
    input wire logic rx_abort,           // Resynchronise the frame counter
    output logic rx_ready,               // Byte may be taken
    output logic reply_valid,            // Reply strobe, one cycle
    output logic [7:0] reply_status,     // Reply status code
    output logic [31:0] reply_value,     // Reply value
    output logic [31:0] accumulator,     // Accumulator register
    output logic nv_req,                 // Nonvolatile access request, held until nv_done
    output logic nv_write,               // 1 write, 0 read
    output logic [1:0] nv_bank,          // Bank of access
    output logic [7:0] nv_index,         // Parameter index
    output logic [31:0] nv_wdata,        // Write data
    input wire logic nv_done,            // Access finished, one cycle
    input wire logic [31:0] nv_rdata,    // Read data valid with nv_done
    output logic booting                 // High while user variables are reloaded
);
    // Refuse bank sizes that the byte-wide type field cannot address
    if (NUM_PARAMS < 1 || NUM_PARAMS > 256) begin : g_bad_params
        $error("NUM_PARAMS out of range");
    end
    localparam int IW = (NUM_PARAMS > 1) ? $clog2(NUM_PARAMS) : 1;
    localparam logic [7:0] LAST_IDX = 8'(NUM_PARAMS - 1);

    // ----------------------------------------
    // Frame assembly
    // ----------------------------------------
    gpc_pkg::gpc_state_t state;
    logic [3:0] pos;
    logic [7:0] sum, f_addr, f_instr, f_type, f_bank;
    logic [31:0] f_value;
    logic [7:0] boot_idx;
    logic [31:0] bank_global [NUM_PARAMS];
    logic [31:0] bank_user [NUM_PARAMS];
    logic [31:0] bank_irq [NUM_PARAMS];

    wire take = rx_valid && rx_ready;
    wire frame_end = take && (pos == gpc_pkg::POS_LAST);
    wire sum_ok = (rx_byte == sum);
    wire for_me = (f_addr == MY_ADDRESS);
    wire in_range = ({1'b0, f_type} <= {1'b0, LAST_IDX});
    wire bank_rw = (f_bank == gpc_pkg::BANK_GLOBAL) || (f_bank == gpc_pkg::BANK_USER)
        || (f_bank == gpc_pkg::BANK_IRQ);
    wire is_set = f_instr == gpc_pkg::INSTR_SET;
    wire is_get = f_instr == gpc_pkg::INSTR_GET;
    wire is_nvop = (f_instr == gpc_pkg::INSTR_STORE) || (f_instr == gpc_pkg::INSTR_RESTORE);
    wire cmd_known = ((is_set || is_get) && bank_rw) || (is_nvop && f_bank == gpc_pkg::BANK_USER);
    wire [IW-1:0] sel = f_type[IW-1:0];
    wire [31:0] read_word = (f_bank == gpc_pkg::BANK_GLOBAL) ? bank_global[sel]
        : (f_bank == gpc_pkg::BANK_USER) ? bank_user[sel] : bank_irq[sel];
    wire needs_nv = (is_set && f_bank == gpc_pkg::BANK_GLOBAL) || is_nvop;
    wire good_cmd = for_me && sum_ok && cmd_known && in_range;
    wire boot_last = (boot_idx == LAST_IDX);

    assign rx_ready = (state == gpc_pkg::GPC_IDLE);
    assign booting = (state == gpc_pkg::GPC_BOOT) || (state == gpc_pkg::GPC_BOOT_WAIT);

    // Byte counter, running checksum and field capture, value MSB first
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pos <= 4'h0;
            sum <= 8'h00;
            f_addr <= 8'h00;
            f_instr <= 8'h00;
            f_type <= 8'h00;
            f_bank <= 8'h00;
            f_value <= 32'h0000_0000;
        end else if (rx_abort) begin
            pos <= 4'h0;
            sum <= 8'h00;
        end else if (take) begin
            pos <= frame_end ? 4'h0 : pos + 4'h1;
            sum <= frame_end ? 8'h00 : sum + rx_byte;
            if (pos == 4'h0) f_addr <= rx_byte;
            if (pos == gpc_pkg::POS_INSTR) f_instr <= rx_byte;
            if (pos == gpc_pkg::POS_TYPE) f_type <= rx_byte;
            if (pos == gpc_pkg::POS_BANK) f_bank <= rx_byte;
            if (pos > gpc_pkg::POS_BANK && pos < gpc_pkg::POS_SUM) begin
                f_value <= {f_value[23:0], rx_byte};
            end
        end
    end

    // ----------------------------------------
    // Command sequencing
    // ----------------------------------------
    logic do_set, do_restore;
    wire boot_done = (state == gpc_pkg::GPC_BOOT_WAIT) && nv_done;
    wire nv_fin = (state == gpc_pkg::GPC_NV) && nv_done;
    assign do_set = frame_end && good_cmd && is_set;
    assign do_restore = nv_fin && !nv_write;

    // Parameter storage, one write port per bank entry
    for (genvar i = 0; i < NUM_PARAMS; i++) begin : g_param
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                bank_global[i] <= 32'h0000_0000;
                bank_user[i] <= 32'h0000_0000;
                bank_irq[i] <= 32'h0000_0000;
            end else begin
                if (do_set && sel == IW'(i) && f_bank == gpc_pkg::BANK_GLOBAL)
                    bank_global[i] <= f_value;
                if (do_set && sel == IW'(i) && f_bank == gpc_pkg::BANK_IRQ)
                    bank_irq[i] <= f_value;
                if ((do_set && sel == IW'(i) && f_bank == gpc_pkg::BANK_USER)
                    || (do_restore && sel == IW'(i)))
                    bank_user[i] <= do_restore ? nv_rdata : f_value;
                if (boot_done && boot_idx[IW-1:0] == IW'(i))
                    bank_user[i] <= nv_rdata;
            end
        end
    end

    // State machine, reply and nonvolatile request
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= gpc_pkg::GPC_BOOT;
            boot_idx <= 8'h00;
            reply_valid <= 1'b0;
            reply_status <= 8'h00;
            reply_value <= 32'h0000_0000;
            accumulator <= 32'h0000_0000;
            nv_req <= 1'b0;
            nv_write <= 1'b0;
            nv_bank <= 2'h0;
            nv_index <= 8'h00;
            nv_wdata <= 32'h0000_0000;
        end else begin
            reply_valid <= 1'b0;
            case (state)
                gpc_pkg::GPC_BOOT: begin
                    nv_req <= 1'b1;
                    nv_write <= 1'b0;
                    nv_bank <= gpc_pkg::BANK_USER[1:0];
                    nv_index <= boot_idx;
                    state <= gpc_pkg::GPC_BOOT_WAIT;
                end
                gpc_pkg::GPC_BOOT_WAIT: begin
                    if (nv_done) begin
                        nv_req <= 1'b0;
                        boot_idx <= boot_last ? 8'h00 : boot_idx + 8'h01;
                        state <= boot_last ? gpc_pkg::GPC_IDLE : gpc_pkg::GPC_BOOT;
                    end
                end
                gpc_pkg::GPC_IDLE: begin
                    if (frame_end && for_me) begin
                        reply_value <= 32'h0000_0000;
                        if (!sum_ok) begin
                            reply_status <= gpc_pkg::STATUS_BAD_SUM;
                            state <= gpc_pkg::GPC_REPLY;
                        end else if (!cmd_known) begin
                            reply_status <= gpc_pkg::STATUS_BAD_CMD;
                            state <= gpc_pkg::GPC_REPLY;
                        end else if (!in_range) begin
                            reply_status <= gpc_pkg::STATUS_BAD_VAL;
                            state <= gpc_pkg::GPC_REPLY;
                        end else begin
                            reply_status <= gpc_pkg::STATUS_OK;
                            if (is_get) begin
                                accumulator <= read_word;
                                reply_value <= read_word;
                            end
                            nv_req <= needs_nv;
                            nv_write <= (f_instr != gpc_pkg::INSTR_RESTORE);
                            nv_bank <= f_bank[1:0];
                            nv_index <= f_type;
                            nv_wdata <= is_set ? f_value : read_word;
                            state <= needs_nv ? gpc_pkg::GPC_NV : gpc_pkg::GPC_REPLY;
                        end
                    end
                end
                gpc_pkg::GPC_NV: begin
                    if (nv_done) begin
                        nv_req <= 1'b0;
                        state <= gpc_pkg::GPC_REPLY;
                    end
                end
                gpc_pkg::GPC_REPLY: begin
                    reply_valid <= 1'b1;
                    state <= gpc_pkg::GPC_IDLE;
                end
                default: state <= gpc_pkg::GPC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Boot reads finished since reset, for the serve-after-boot check
    logic [8:0] boot_reads;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            boot_reads <= 9'h000;
        end else if (boot_done) begin
            boot_reads <= boot_reads + 9'h001;
        end
    end
    chk_get_accum: assert property (@(posedge clock) disable iff (!reset_n)
        (state == gpc_pkg::GPC_IDLE && frame_end && good_cmd && is_get)
        |=> accumulator == $past(read_word))
        else $error("get did not load accumulator");
    chk_get_reply: assert property (@(posedge clock) disable iff (!reset_n)
        (state == gpc_pkg::GPC_IDLE && frame_end && good_cmd && is_get)
        |=> ##1 reply_valid && reply_status == gpc_pkg::STATUS_OK && reply_value == accumulator)
        else $error("get reply wrong");
    chk_set_write: assert property (@(posedge clock) disable iff (!reset_n)
        (do_set && f_bank == gpc_pkg::BANK_IRQ) |=> bank_irq[$past(sel)] == $past(f_value))
        else $error("set did not write");
    chk_global_commit: assert property (@(posedge clock) disable iff (!reset_n)
        (do_set && f_bank == gpc_pkg::BANK_GLOBAL) |=> nv_req && nv_write && nv_bank == 2'h0)
        else $error("bank 0 set not committed");
    chk_store_user: assert property (@(posedge clock) disable iff (!reset_n)
        (state == gpc_pkg::GPC_IDLE && frame_end && good_cmd
            && f_instr == gpc_pkg::INSTR_STORE) |=> nv_req && nv_write && nv_wdata == $past(read_word))
        else $error("store not issued");
    chk_restore_user: assert property (@(posedge clock) disable iff (!reset_n)
        do_restore |=> bank_user[$past(sel)] == $past(nv_rdata))
        else $error("restore not applied");
    chk_boot_block: assert property (@(posedge clock) disable iff (!reset_n)
        rx_ready |-> !booting && boot_reads == 9'(NUM_PARAMS))
        else $error("commands served during boot");
    chk_bad_sum: assert property (@(posedge clock) disable iff (!reset_n)
        (rx_ready && frame_end && for_me && !sum_ok)
        |=> ##1 reply_valid && reply_status == gpc_pkg::STATUS_BAD_SUM && !nv_req)
        else $error("bad checksum accepted");
    chk_bank_refuse: assert property (@(posedge clock) disable iff (!reset_n)
        (rx_ready && frame_end && for_me && sum_ok && (is_set || is_get) && !bank_rw)
        |=> reply_status == gpc_pkg::STATUS_BAD_CMD)
        else $error("bad bank accepted");
    chk_ok_reply: assert property (@(posedge clock) disable iff (!reset_n)
        (nv_fin) |=> ##1 reply_valid && reply_status == gpc_pkg::STATUS_OK)
        else $error("nonvolatile op reply wrong");
    cov_get: cover property (@(posedge clock) disable iff (!reset_n)
        reply_valid && reply_status == gpc_pkg::STATUS_OK && f_instr == gpc_pkg::INSTR_GET);
    cov_store: cover property (@(posedge clock) disable iff (!reset_n)
        nv_fin && nv_write && f_instr == gpc_pkg::INSTR_STORE);
    cov_restore: cover property (@(posedge clock) disable iff (!reset_n) do_restore);
    cov_bad_sum: cover property (@(posedge clock) disable iff (!reset_n)
        reply_valid && reply_status == gpc_pkg::STATUS_BAD_SUM);
endmodule : gpc_handler

// File: rtl/gpc_pkg.sv
// Constants shared by the global parameter command handler.
// Assumes a byte-wide frame source and a word-wide nonvolatile store port.
package gpc_pkg;
    // ----------------------------------------
    // Frame layout and instruction codes
    // ----------------------------------------
    localparam int FRAME_BYTES = 9;
    localparam logic [7:0] INSTR_SET = 8'h09;
    localparam logic [7:0] INSTR_GET = 8'h0A;
    localparam logic [7:0] INSTR_STORE = 8'h0B;
    localparam logic [7:0] INSTR_RESTORE = 8'h0C;
    localparam logic [7:0] BANK_GLOBAL = 8'h00;
    localparam logic [7:0] BANK_USER = 8'h02;
    localparam logic [7:0] BANK_IRQ = 8'h03;
    // Reply status codes
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_VAL = 8'h04;
    // Frame byte positions
    localparam logic [3:0] POS_INSTR = 4'h1;
    localparam logic [3:0] POS_TYPE = 4'h2;
    localparam logic [3:0] POS_BANK = 4'h3;
    localparam logic [3:0] POS_SUM = 4'h8;
    localparam logic [3:0] POS_LAST = 4'h8;
    // ----------------------------------------
    // Controller states, one-hot
    // ----------------------------------------
    typedef enum logic [4:0] {
        GPC_BOOT = 5'h01,
        GPC_BOOT_WAIT = 5'h02,
        GPC_IDLE = 5'h04,
        GPC_NV = 5'h08,
        GPC_REPLY = 5'h10
    } gpc_state_t;
endpackage : gpc_pkg

// File: bench/gpc_nv_model.sv
// Nonvolatile store model for the global parameter command handler.
// Assumes one access at a time; answers after wait_cycles plus one cycle.
`timescale 1ns/1ns
module gpc_nv_model (
    input wire logic clock,             // System clock
    input wire logic reset_n,           // Async reset, active low
    input wire logic [3:0] wait_cycles, // Extra answer delay
    input wire logic nv_req,            // Access request
    input wire logic nv_write,          // 1 write, 0 read
    input wire logic [1:0] nv_bank,     // Bank of access
    input wire logic [7:0] nv_index,    // Parameter index
    input wire logic [31:0] nv_wdata,   // Write data
    output logic nv_done,               // One-cycle finish pulse
    output logic [31:0] nv_rdata        // Read data, valid with nv_done
);
    logic [31:0] mem [4][4];
    logic [3:0] cnt;
    // Stored contents survive reset, so fill them once
    initial begin
        for (int b = 0; b < 4; b++) begin
            for (int i = 0; i < 4; i++) begin
                mem[b][i] = 32'hC0DE0000 + 32'(b * 16 + i);
            end
        end
    end
    // Wait, then finish; stale read data is shown inverted afterwards
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 4'h0;
            nv_done <= 1'b0;
            nv_rdata <= 32'h0;
        end else begin
            nv_done <= 1'b0;
            if (nv_done) begin
                nv_rdata <= ~nv_rdata;
            end
            if (nv_req && !nv_done) begin
                cnt <= cnt + 4'h1;
                if (cnt >= wait_cycles) begin
                    cnt <= 4'h0;
                    nv_done <= 1'b1;
                    if (nv_write) begin
                        mem[nv_bank][nv_index[1:0]] <= nv_wdata;
                    end else begin
                        nv_rdata <= mem[nv_bank][nv_index[1:0]];
                    end
                end
            end
        end
    end
endmodule : gpc_nv_model

// File: bench/tb_gpc_handler.sv
// Self-checking bench for the global parameter command handler.
// Assumes NUM_PARAMS of 4 and the nonvolatile store model beside it.
`timescale 1ns/1ns
module tb_gpc_handler;
    localparam int NP = 4;
    localparam logic [7:0] MY = 8'h01;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic rx_abort = 1'b0;
    logic [3:0] wait_cycles = 4'h2;
    logic rx_ready, reply_valid, nv_req, nv_write, nv_done, booting;
    logic [7:0] reply_status, nv_index, got_status;
    logic [31:0] reply_value, accumulator, nv_wdata, nv_rdata, got_value, v;
    logic [1:0] nv_bank;
    logic [31:0] shadow [4][4];
    bit known [4][4];
    bit replied;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 76596;
    int b, t;
    // Refusal table: instruction, bank, expected status; the type is computed from the entry number
    logic [7:0] bad_i [6] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h05, 8'h0A};
    logic [7:0] bad_b [6] = '{8'h01, 8'h04, 8'h00, 8'h03, 8'h00, 8'h02};
    logic [7:0] bad_s [6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h04};

    gpc_handler #(.NUM_PARAMS(NP), .MY_ADDRESS(MY)) u_gpc_handler (.clock(clock),
        .reset_n(reset_n), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_abort(rx_abort),
        .rx_ready(rx_ready), .reply_valid(reply_valid), .reply_status(reply_status),
        .reply_value(reply_value), .accumulator(accumulator), .nv_req(nv_req),
        .nv_write(nv_write), .nv_bank(nv_bank), .nv_index(nv_index), .nv_wdata(nv_wdata),
        .nv_done(nv_done), .nv_rdata(nv_rdata), .booting(booting));
    gpc_nv_model u_gpc_nv_model (.clock(clock), .reset_n(reset_n), .wait_cycles(wait_cycles),
        .nv_req(nv_req), .nv_write(nv_write), .nv_bank(nv_bank), .nv_index(nv_index),
        .nv_wdata(nv_wdata), .nv_done(nv_done), .nv_rdata(nv_rdata));

    // Clock and hang guard
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] fsum(input logic [7:0] a, i, ty, bk, input logic [31:0] x);
        return a + i + ty + bk + x[31:24] + x[23:16] + x[15:8] + x[7:0];
    endfunction : fsum
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic send_byte(input logic [7:0] d);
        for (int k = 0; k < 2000 && rx_ready !== 1'b1; k++) @(negedge clock);
        rx_valid = 1'b1;
        rx_byte = d;
        @(negedge clock);
    endtask : send_byte
    task automatic cmd(input logic [7:0] a, i, ty, bk, input logic [31:0] x, input bit bad);
        logic [7:0] fr [9];
        fr = '{a, i, ty, bk, x[31:24], x[23:16], x[15:8], x[7:0], fsum(a, i, ty, bk, x) ^ 8'(bad)};
        foreach (fr[n]) send_byte(fr[n]);
        rx_valid = 1'b0;
        replied = 1'b0;
        for (int k = 0; k < 60 && !replied; k++) begin
            if (reply_valid === 1'b1) begin
                replied = 1'b1;
                got_status = reply_status;
                got_value = reply_value;
            end else begin
                @(negedge clock);
            end
        end
        check("reply seen", 32'(replied), 32'(a == MY));
    endtask : cmd
    task automatic set_p(input int bk, ty, input logic [31:0] x);
        cmd(MY, gpc_pkg::INSTR_SET, 8'(ty), 8'(bk), x, 1'b0);
        check("set status", got_status, gpc_pkg::STATUS_OK);
        shadow[bk][ty] = x;
        known[bk][ty] = 1'b1;
    endtask : set_p
    task automatic get_p(input int bk, ty);
        cmd(MY, gpc_pkg::INSTR_GET, 8'(ty), 8'(bk), $random(seed), 1'b0);
        check("get status", got_status, gpc_pkg::STATUS_OK);
        check("get value", got_value, shadow[bk][ty]);
        check("accumulator", accumulator, shadow[bk][ty]);
    endtask : get_p
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        check("booting", booting, 1'b1);
        for (int i = 0; i < NP; i++) begin
            shadow[2][i] = u_gpc_nv_model.mem[2][i];
            get_p(2, i);
        end
        check("booting done", booting, 1'b0);
        v = $random(seed);
        set_p(0, 1, v);
        check("auto commit", u_gpc_nv_model.mem[0][1], v);
        get_p(0, 1);
        set_p(2, 2, v);
        cmd(MY, gpc_pkg::INSTR_STORE, 8'h02, 8'h02, $random(seed), 1'b0);
        check("store status", got_status, gpc_pkg::STATUS_OK);
        check("stored word", u_gpc_nv_model.mem[2][2], v);
        set_p(2, 2, ~v);
        cmd(MY, gpc_pkg::INSTR_RESTORE, 8'h02, 8'h02, 32'h0, 1'b0);
        check("restore status", got_status, gpc_pkg::STATUS_OK);
        shadow[2][2] = v;
        get_p(2, 2);
        for (int n = 0; n < 6; n++) begin
            cmd(MY, bad_i[n], 8'(n % NP + 4 * (n / 5)), bad_b[n], ~v, 1'b0);
            check("refused status", got_status, bad_s[n]);
            get_p(2, 2);
        end
        cmd(MY, gpc_pkg::INSTR_SET, 8'h02, 8'h02, 32'h12345678, 1'b1);
        check("bad sum status", got_status, gpc_pkg::STATUS_BAD_SUM);
        get_p(2, 2);
        cmd(MY + 8'h01, gpc_pkg::INSTR_SET, 8'h02, 8'h02, 32'h0, 1'b0);
        check("foreign reply", 32'(replied), 32'h0);
        repeat (3) send_byte(8'hA5);
        rx_valid <= 1'b0;
        rx_abort <= 1'b1;
        @(negedge clock);
        rx_abort = 1'b0;
        get_p(2, 2);
        set_p(3, 3, 32'h11223344);
        get_p(3, 3);
        for (int n = 0; n < 24; n++) begin
            wait_cycles = 4'($random(seed));
            b = ($random(seed) & 1) ? 2 : (($random(seed) & 1) ? 3 : 0);
            set_p(b, $random(seed) & 3, $random(seed));
            b = $random(seed) & 3;
            t = $random(seed) & 3;
            if (known[b][t]) get_p(b, t);
        end
        final_report();
    end
endmodule : tb_gpc_handler
